// ### core/irq_latch_core.sv
// Core interrupt latch, mask, mask pointer and interval timer.
// Assumes event inputs are on clk_in except the two pins, which are
// synchronised here; software uses the plain register port.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "irq_latch_consts.svh"
module irq_latch_core
	import irq_latch_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pins, asynchronous, active low
	input wire logic emulator_request_pin_n_in,
	input wire logic reset_pin_n_in,
	// Core event sources, on clk_in
	input wire logic illegal_io_access_flag_in,
	input wire logic unaligned_wide_access_flag_in,
	input wire logic stack_overflow_in,
	input wire logic breakpoint_in,
	// Service acknowledge, one-cycle pulse with bit number
	input wire logic service_ack_in,
	input wire logic [4:0] service_num_in,
	// Register port
	input wire addr_t addr_in,
	input wire word_t wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output word_t rd_data_out,
	// Interrupt request to sequencer
	output logic irq_pending_out,
	output logic [4:0] irq_num_out,
	output logic irq_out
);
	word_t interrupt_latch_reg;
	word_t interrupt_mask_reg;
	word_t mask_pointer_reg;
	word_t secondary_latch_reg;
	word_t mode_control_two_reg;
	word_t timer_period_reg;
	word_t rd_data_reg;
	logic [`NUM_EVT-1:0] irq_status_reg;
	logic [`NUM_EVT-1:0] irq_mask_reg;
	logic irq_reg;
	logic irq_pending_reg;
	logic [4:0] irq_num_reg;
	logic emu_sync1_reg;
	logic emu_sync2_reg;
	logic rst_sync1_reg;
	logic rst_sync2_reg;
	logic pin_reset_seen_reg;
	logic power_on_reg;
	word_t timer_counter;
	logic timer_zero;
	logic [`NUM_SRC-1:0] src_evt;
	word_t pend_unmasked;
	logic pend_found;
	logic [4:0] pend_num;
	logic wr_latch;
	logic wr_sec;

	// Pin synchronisers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			emu_sync1_reg <= 1'b1;
			emu_sync2_reg <= 1'b1;
		end else begin
			emu_sync1_reg <= emulator_request_pin_n_in;
			emu_sync2_reg <= emu_sync1_reg;
		end
	end

	// Reset pin sampled through reset, so release sees its level
	always_ff @(posedge clk_in) begin
		rst_sync1_reg <= reset_pin_n_in;
		rst_sync2_reg <= rst_sync1_reg;
	end

	// Reset occurrence, caught after release
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_on_reg <= 1'b1;
			pin_reset_seen_reg <= 1'b0;
		end else begin
			power_on_reg <= 1'b0;
			pin_reset_seen_reg <= power_on_reg && !rst_sync2_reg;
		end
	end

	interval_timer u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.enable_in(mode_control_two_reg[`BIT_TIMER_EN]),
		.period_in(timer_period_reg),
		.count_wr_in(wr_en_in && addr_in == `ADDR_COUNT),
		.count_data_in(wr_data_in),
		.count_out(timer_counter),
		.zero_out(timer_zero)
	);

	always_comb begin
		src_evt = '0;
		src_evt[`BIT_EMU] = power_on_reg || !emu_sync2_reg;
		src_evt[`BIT_RESET] = pin_reset_seen_reg;
		src_evt[`BIT_ILLEGAL] = illegal_io_access_flag_in ||
			unaligned_wide_access_flag_in;
		src_evt[`BIT_STACK] = stack_overflow_in;
		src_evt[`BIT_TMR_HIGH] = timer_zero;
		src_evt[`BIT_RSVD] = 1'b0;
		src_evt[`BIT_BREAK] = breakpoint_in;
	end

	assign wr_latch = wr_en_in && addr_in == `ADDR_LATCH;
	assign wr_sec = wr_en_in && addr_in == `ADDR_SEC_LATCH;

	// Latch register, one bit per source
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_latch
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					interrupt_latch_reg[gi] <= 1'(`RST_LATCH >> gi);
				end else if (gi < `NUM_SRC && src_evt[gi % `NUM_SRC]) begin
					interrupt_latch_reg[gi] <= 1'b1;
				end else if (wr_latch) begin
					interrupt_latch_reg[gi] <= wr_data_in[gi] &&
						gi < `NUM_SRC && gi != `BIT_RSVD;
				end else if (service_ack_in && service_num_in == gi) begin
					interrupt_latch_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			secondary_latch_reg <= `RST_SEC_LATCH;
		else if (timer_zero)
			secondary_latch_reg[`BIT_TMR_LOW] <= 1'b1;
		else if (wr_sec)
			secondary_latch_reg[`BIT_TMR_LOW] <= wr_data_in[`BIT_TMR_LOW];
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			interrupt_mask_reg <= `RST_MASK;
		else if (wr_en_in && addr_in == `ADDR_MASK)
			interrupt_mask_reg <= wr_data_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mask_pointer_reg <= `RST_MASK_PTR;
		else if (wr_en_in && addr_in == `ADDR_MASK_PTR)
			mask_pointer_reg <= wr_data_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mode_control_two_reg <= `RST_MODE_TWO;
		else if (wr_en_in && addr_in == `ADDR_MODE_TWO)
			mode_control_two_reg <= wr_data_in;
	end

	always_ff @(posedge clk_in) begin
		if (wr_en_in && addr_in == `ADDR_PERIOD)
			timer_period_reg <= wr_data_in;
	end

	always_comb begin
		pend_unmasked = interrupt_latch_reg & interrupt_mask_reg;
		pend_unmasked[`BIT_EMU] = interrupt_latch_reg[`BIT_EMU];
		pend_unmasked[`BIT_RESET] = interrupt_latch_reg[`BIT_RESET];
		pend_found = 1'b0;
		pend_num = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (pend_unmasked[i]) begin
				pend_found = 1'b1;
				pend_num = 5'(i);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_pending_reg <= 1'b0;
			irq_num_reg <= 5'h00;
		end else begin
			irq_pending_reg <= pend_found;
			irq_num_reg <= pend_num;
		end
	end

	// Event status for the interrupt output; write one to clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_status_reg <= '0;
		end else begin
			for (int e = 0; e < `NUM_EVT; e++) begin
				if (e == `EVT_TIMER ? timer_zero : src_evt[`BIT_ILLEGAL])
					irq_status_reg[e] <= 1'b1;
				else if (wr_en_in && addr_in == `ADDR_IRQ_STATUS &&
					wr_data_in[e])
					irq_status_reg[e] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			irq_mask_reg <= `NUM_EVT'(`RST_IRQ_MASK);
		else if (wr_en_in && addr_in == `ADDR_IRQ_MASK)
			irq_mask_reg <= wr_data_in[`NUM_EVT-1:0];
	end

	// Level output registered from the current status register value masked by irq_mask_reg
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(irq_status_reg & irq_mask_reg);
	end

	// Read data one cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (rd_en_in) begin
			case (addr_in)
				`ADDR_LATCH: rd_data_reg <= interrupt_latch_reg;
				`ADDR_MASK: rd_data_reg <= interrupt_mask_reg;
				`ADDR_MASK_PTR: rd_data_reg <= mask_pointer_reg;
				`ADDR_SEC_LATCH: rd_data_reg <= secondary_latch_reg;
				`ADDR_MODE_TWO: rd_data_reg <= mode_control_two_reg;
				`ADDR_PERIOD: rd_data_reg <= timer_period_reg;
				`ADDR_COUNT: rd_data_reg <= timer_counter;
				`ADDR_IRQ_STATUS:
					rd_data_reg <= {{(32-`NUM_EVT){1'b0}}, irq_status_reg};
				`ADDR_IRQ_MASK:
					rd_data_reg <= {{(32-`NUM_EVT){1'b0}}, irq_mask_reg};
				`ADDR_ACTIVE:
					rd_data_reg <= {26'h0, irq_pending_reg, irq_num_reg};
				default: rd_data_reg <= 32'h0000_0000;
			endcase
		end else begin
			rd_data_reg <= 32'h0000_0000;
		end
	end

	assign rd_data_out = rd_data_reg;
	assign irq_pending_out = irq_pending_reg;
	assign irq_num_out = irq_num_reg;
	assign irq_out = irq_reg;
endmodule

// ### core/irq_latch_consts.svh
// Register offsets, field positions and reset values of the interrupt latch.
// Included by the package, the core, the checker and the testbench; definitions only.
`ifndef IRQ_LATCH_CONSTS_SVH
`define IRQ_LATCH_CONSTS_SVH

// Register word addresses
`define ADDR_LATCH 4'h0
`define ADDR_MASK 4'h1
`define ADDR_MASK_PTR 4'h2
`define ADDR_SEC_LATCH 4'h3
`define ADDR_MODE_TWO 4'h4
`define ADDR_PERIOD 4'h5
`define ADDR_COUNT 4'h6
`define ADDR_IRQ_STATUS 4'h7
`define ADDR_IRQ_MASK 4'h8
`define ADDR_ACTIVE 4'h9

// Latch bit positions
`define BIT_EMU 0
`define BIT_RESET 1
`define BIT_ILLEGAL 2
`define BIT_STACK 3
`define BIT_TMR_HIGH 4
`define BIT_RSVD 5
`define BIT_BREAK 6
`define NUM_SRC 7
// Secondary latch: low-priority timer bit
`define BIT_TMR_LOW 0
// Second mode control: timer enable bit
`define BIT_TIMER_EN 5

// Reset values
`define RST_LATCH 32'h0000_0000
`define RST_MASK 32'h0000_0003
`define RST_MASK_PTR 32'h0000_0000
`define RST_SEC_LATCH 32'h0000_0000
`define RST_MODE_TWO 32'h0000_0000
`define RST_IRQ_MASK 32'h0000_0000

// Status register bits of the interrupt output
`define EVT_TIMER 0
`define EVT_ERROR 1
`define NUM_EVT 2

`endif

// ### core/irq_latch_pkg.sv
// Types shared by the interrupt latch design.
// Assumes the constants header is on the include path.
`include "irq_latch_consts.svh"
package irq_latch_pkg;
	typedef logic [31:0] word_t;
	typedef logic [3:0] addr_t;
	typedef enum logic [2:0] {
		TMR_STOP = 3'b001,
		TMR_LOAD = 3'b010,
		TMR_RUN = 3'b100
	} timer_state_t;
endpackage

// ### core/interval_timer.sv
// Core interval timer: decrements while enabled, reloads from period.
// Assumes one clock and an async active-low reset; period/count loaded
// by the parent's register port.
`timescale 1ns/1ns
module interval_timer
	import irq_latch_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic enable_in,
	input wire word_t period_in,
	input wire logic count_wr_in,
	input wire word_t count_data_in,
	// Status
	output word_t count_out,
	output logic zero_out
);
	timer_state_t state_reg;
	word_t count_reg;
	logic zero_reg;

	assign count_out = count_reg;
	assign zero_out = zero_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= TMR_STOP;
		end else begin
			case (state_reg)
				TMR_STOP: begin
					if (enable_in)
						state_reg <= TMR_RUN;
				end
				TMR_RUN, TMR_LOAD: begin
					if (!enable_in)
						state_reg <= TMR_STOP;
					else
						state_reg <= TMR_RUN;
				end
				default: state_reg <= TMR_STOP;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (count_wr_in) begin
			count_reg <= count_data_in;
		end else if (state_reg == TMR_RUN && enable_in) begin
			if (count_reg == 32'h0000_0000)
				count_reg <= period_in;
			else
				count_reg <= count_reg - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			zero_reg <= 1'b0;
		else
			zero_reg <= !count_wr_in && state_reg == TMR_RUN && enable_in &&
				count_reg == 32'h0000_0001;
	end
endmodule

// ### sim/irq_latch_chk.sv
// Port-level checker for the interrupt latch core.
// Assumes binding to irq_latch_core; one clock, async active-low reset.
`timescale 1ns/1ns
`include "irq_latch_consts.svh"
module irq_latch_chk
	import irq_latch_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Event sources and service acknowledge
	input wire logic emulator_request_pin_n_in,
	input wire logic illegal_io_access_flag_in,
	input wire logic unaligned_wide_access_flag_in,
	input wire logic stack_overflow_in,
	input wire logic breakpoint_in,
	input wire logic service_ack_in,
	// Register port and request
	input wire addr_t addr_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire word_t rd_data_out,
	input wire logic irq_pending_out,
	input wire logic [4:0] irq_num_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic rd_latch;
	assign rd_latch = rd_en_in && addr_in == `ADDR_LATCH;
	chk_read_idle_zero: assert property (
		!$past(rd_en_in) |-> rd_data_out == 32'h0) else $error("idle read");
	chk_emu_pending: assert property (
		!emulator_request_pin_n_in |-> ##[1:6]
		(irq_pending_out && irq_num_out == 5'h0)) else $error("emu lost");
	chk_illegal_latched: assert property (
		rd_latch && ($past(illegal_io_access_flag_in) ||
		$past(unaligned_wide_access_flag_in)) |=> rd_data_out[2])
		else $error("illegal input not latched");
	chk_stack_latched: assert property (
		rd_latch && $past(stack_overflow_in) |=> rd_data_out[3])
		else $error("stack overflow not latched");
	chk_break_latched: assert property (
		rd_latch && $past(breakpoint_in) |=> rd_data_out[6])
		else $error("breakpoint not latched");
	chk_reserved_zero: assert property (
		rd_latch |=> !rd_data_out[5] && rd_data_out[31:7] == 25'h0)
		else $error("reserved latch bit set");
	chk_num_range: assert property (
		irq_pending_out |-> irq_num_out <= 5'h6 && irq_num_out != 5'h5)
		else $error("bad pending number");
	chk_pending_holds: assert property (
		irq_pending_out && !service_ack_in && !$past(service_ack_in) &&
		!wr_en_in && !$past(wr_en_in) |=> irq_pending_out)
		else $error("pending dropped");
endmodule

// ### sim/irq_latch_core_tb_top.sv
// Testbench for the interrupt latch core: register tasks and scenarios.
// Assumes the core, its package and the checker are compiled first.
`timescale 1ns/1ns
`include "irq_latch_consts.svh"
module irq_latch_core_tb_top;
	import irq_latch_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic emulator_request_pin_n_in, reset_pin_n_in, service_ack_in;
	logic wr_en_in, rd_en_in, irq_pending_out, irq_out;
	logic [3:0] src;
	logic [4:0] service_num_in, irq_num_out;
	addr_t addr_in;
	word_t wr_data_in, rd_data_out, d, c0;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	int t0;
	word_t src_tab[5] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'hc};
	word_t exp_tab[5] = '{32'h4, 32'h4, 32'h8, 32'h40, 32'h48};
	wire illegal_io_access_flag_in = src[0];
	wire unaligned_wide_access_flag_in = src[1];
	wire stack_overflow_in = src[2];
	wire breakpoint_in = src[3];
	irq_latch_core uut (.*);
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run();
		end
	end
	task complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input word_t got, input word_t exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input addr_t a, input word_t v);
		@(posedge clk_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= v;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask
	task rd(input addr_t a, output word_t v);
		@(posedge clk_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1 v = rd_data_out;
	endtask
	task rdchk(input addr_t a, input word_t exp);
		word_t v;
		rd(a, v);
		chk(v, exp);
	endtask
	// Waits for the interrupt output, bounded
	task wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			#1 n++;
		end while (irq_out !== 1'b1 && n < 300);
	endtask
	initial begin
		{wr_en_in, rd_en_in, service_ack_in, src} = '0;
		addr_in = '0;
		wr_data_in = '0;
		service_num_in = '0;
		emulator_request_pin_n_in = 1'b1;
		reset_pin_n_in = 1'b0;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_pin_n_in <= 1'b1;
		rdchk(`ADDR_MASK, 32'h3);
		rdchk(`ADDR_MASK_PTR, 32'h0);
		rdchk(`ADDR_SEC_LATCH, 32'h0);
		rdchk(`ADDR_LATCH, 32'h3);
		wr(`ADDR_LATCH, 32'hffff_ffff);
		rdchk(`ADDR_LATCH, 32'h5f);
		wr(`ADDR_LATCH, 32'h0);
		rdchk(`ADDR_LATCH, 32'h0);
		// Each source alone, then two together, all masked
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_in);
			src <= src_tab[i][3:0];
			@(posedge clk_in);
			src <= 4'h0;
			rd_en_in <= 1'b1;
			addr_in <= `ADDR_LATCH;
			@(posedge clk_in);
			rd_en_in <= 1'b0;
			#1 chk(rd_data_out, exp_tab[i]);
			if (i < 4)
				wr(`ADDR_LATCH, 32'h0);
		end
		rdchk(`ADDR_ACTIVE, 32'h0);
		wr(`ADDR_MASK, 32'h48);
		rdchk(`ADDR_ACTIVE, 32'h23);
		wr(`ADDR_LATCH, 32'h40);
		rdchk(`ADDR_ACTIVE, 32'h26);
		wr(`ADDR_MASK, 32'h0);
		wr(`ADDR_LATCH, 32'h0);
		@(posedge clk_in);
		emulator_request_pin_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		emulator_request_pin_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		rdchk(`ADDR_LATCH, 32'h1);
		chk({26'h0, irq_pending_out, irq_num_out}, 32'h20);
		@(posedge clk_in);
		service_ack_in <= 1'b1;
		@(posedge clk_in);
		service_ack_in <= 1'b0;
		rdchk(`ADDR_LATCH, 32'h0);
		wr(`ADDR_PERIOD, 32'd100);
		wr(`ADDR_COUNT, 32'd60);
		wr(`ADDR_MODE_TWO, 32'h20);
		rd(`ADDR_COUNT, c0);
		rd(`ADDR_COUNT, d);
		chk(d, c0 - 32'd2);
		wr(`ADDR_MODE_TWO, 32'h0);
		rd(`ADDR_COUNT, c0);
		repeat (3) @(posedge clk_in);
		rdchk(`ADDR_COUNT, c0);
		wr(`ADDR_PERIOD, 32'd8);
		wr(`ADDR_COUNT, 32'd2);
		wr(`ADDR_IRQ_MASK, 32'h1);
		wr(`ADDR_MODE_TWO, 32'h20);
		wait_irq();
		t0 = cycles;
		wr(`ADDR_IRQ_STATUS, 32'h1);
		wait_irq();
		chk(word_t'(cycles - t0), 32'd9);
		chk({31'h0, irq_out}, 32'h1);
		wr(`ADDR_MODE_TWO, 32'h0);
		rdchk(`ADDR_LATCH, 32'h10);
		rdchk(`ADDR_SEC_LATCH, 32'h1);
		complete_run();
	end
endmodule
bind irq_latch_core irq_latch_chk chk_i (.*);
